// >>> esl_pkg.sv
// ************************************************************
// Shared constants and types of the setting load control.
// ************************************************************
package esl_pkg;

    // Clock rate and timing figures.
    localparam int CLK_HZ = 20000000;
    localparam int STABLE_MS = 10;
    localparam int STABLE_CYC = STABLE_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 18;

    // Register byte offsets.
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_STATUS = 5'h04;
    localparam logic [4:0] OFF_IRQ_STAT = 5'h08;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h0c;
    localparam logic [4:0] OFF_LAST = 5'h10;
    localparam logic [4:0] OFF_UPPER = 5'h14;
    localparam logic [4:0] OFF_LOWER = 5'h18;
    localparam logic [4:0] OFF_ACK = 5'h1c;

    // Control register fields and reset value.
    localparam int CTRL_SCAN_LSB = 0;
    localparam int CTRL_DEC_BIT = 2;
    localparam int CTRL_EXT_BIT = 3;
    localparam logic [3:0] CTRL_RST = 4'h8;

    // Interrupt event bit positions.
    localparam int EV_LOAD = 0;
    localparam int EV_MEAS = 1;
    localparam int EV_REFUSE = 2;
    localparam int EV_RESTART = 3;
    localparam int EV_W = 4;

    // Select code and digit widths.
    localparam int CODE_W = 6;
    localparam int DIG_W = 16;
    localparam logic [5:0] CODE_NONE = 6'h00;

    // Scan function setting.
    typedef enum logic [1:0] {
        SCAN_OFF = 2'b00,
        SCAN_AUTO = 2'b01,
        SCAN_STEP = 2'b10
    } esl_scan_t;

    // Request handed to the measurement sequencer.
    typedef struct packed {
        logic valid;
        logic measure_only;
        logic is_channel;
        logic switch_ch;
        logic first_channel;
        logic [5:0] code;
    } esl_req_t;

    // Synchronised pin bundle.
    typedef struct packed {
        logic measure_start_input;
        logic restart;
        logic multiplexer_mode_input;
        logic half;
        logic leads;
        logic [1:0] spare;
        logic [5:0] code;
    } esl_pins_t;

endpackage : esl_pkg

// >>> esl_sync2.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Two-stage synchroniser for a bundle of pin levels.
// ************************************************************
module esl_sync2 #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Levels.
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : esl_sync2
`default_nettype wire

// >>> esl_top.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - In step scan, a restart seen while idle makes the next trigger measure the first channel.
// - With decimal output on, half select low drives upper digits, high drives lower digits.
// - A trigger loads the panel or channel named by the select code, switches, then measures.
// - Select input 0 is the least significant bit and input 5 the most significant.
// - Under external triggering, a trigger with the previous code measures once without loading.
// - A non-zero code held unchanged for 10 ms loads without a trigger; the code does so only if it differs from the last loaded code.
// - Select inputs stay honoured under remote control.
// - Front panel keys are locked out while a valid code is presented.
// - In auto or step scan the select inputs never change the channel.
// - A channel switch asked for while front leads are attached raises the fault and is refused.
// - Two spare inputs are readable through the status register.
// - The multiplexer mode input decides whether the code names a panel or a channel.
// - The restart input acts only in auto or step scan.
module esl_top #(
    parameter int STABLE_CYCLES = esl_pkg::STABLE_CYC
) (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Control port pins.
    input wire logic measure_start_in,
    input wire logic scan_restart_in,
    input wire logic [5:0] setting_select_in,
    input wire logic multiplexer_mode_in,
    input wire logic digit_half_select_in,
    input wire logic front_leads_in,
    input wire logic [1:0] spare_in,
    // Avalon-MM slave.
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Results.
    output esl_pkg::esl_req_t load_req_out,
    output logic fault_out,
    output logic key_lock_out,
    output logic [15:0] digits_out,
    output logic irq_out
);
    import esl_pkg::*;

    // ********************************************************
    // Helper functions.
    // ********************************************************

    // True while the scan function is auto or step.
    function automatic logic scan_on(input logic [1:0] mode);
        scan_on = (mode == SCAN_AUTO) || (mode == SCAN_STEP);
    endfunction : scan_on

    // Apply write-one-to-clear while keeping new events.
    function automatic logic [EV_W-1:0] w1c(input logic [EV_W-1:0] cur,
            input logic [EV_W-1:0] clr, input logic [EV_W-1:0] set);
        w1c = (cur & ~clr) | set;
    endfunction : w1c

    // ********************************************************
    // Pin synchronisation and edges.
    // ********************************************************

    esl_pins_t raw_pins;
    esl_pins_t pins;
    esl_pins_t pins_q;
    logic measure_start_input_rise;
    logic restart_rise;

    // Bundle the pins, select bit 0 as LSB.
    assign raw_pins = '{measure_start_input: measure_start_in, restart: scan_restart_in,
        multiplexer_mode_input: multiplexer_mode_in, half: digit_half_select_in,
        leads: front_leads_in, spare: spare_in,
        code: setting_select_in};

    esl_sync2 #(.W($bits(esl_pins_t))) u_sync (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .async_in(raw_pins),
        .sync_out(pins)
    );

    // Previous synchronised levels for edge detection.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            pins_q <= '0;
        end else begin
            pins_q <= pins;
        end
    end

    // Off-to-on edges.
    assign measure_start_input_rise = pins.measure_start_input && !pins_q.measure_start_input;
    assign restart_rise = pins.restart && !pins_q.restart;

    // ********************************************************
    // Register state.
    // ********************************************************

    logic [3:0] ctrl_q;
    logic [EV_W-1:0] irq_stat_q;
    logic [EV_W-1:0] irq_mask_q;
    logic [15:0] upper_q;
    logic [15:0] lower_q;
    logic [5:0] last_code_q;
    logic busy_q;
    logic restart_pend_q;
    logic [CNT_W-1:0] stable_cnt_q;
    logic stable_arm_q;
    logic [1:0] scan_mode;
    logic wr_acc;
    logic ack_wr;

    assign scan_mode = ctrl_q[CTRL_SCAN_LSB +: 2];
    assign wr_acc = avs_write && !avs_waitrequest;
    assign ack_wr = wr_acc && (avs_address == OFF_ACK) && avs_writedata[0];

    // ********************************************************
    // Stable code timer.
    // ********************************************************

    logic stable_fire;

    // Fires once when a non-zero code holds still for the full time.
    assign stable_fire = stable_arm_q &&
        (stable_cnt_q == CNT_W'(STABLE_CYCLES - 1));

    // Restart the count on every code change.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            stable_cnt_q <= '0;
            stable_arm_q <= 1'b0;
        end else if (pins.code != pins_q.code) begin
            stable_cnt_q <= '0;
            stable_arm_q <= (pins.code != CODE_NONE);
        end else if (stable_fire) begin
            stable_arm_q <= 1'b0;
        end else if (stable_arm_q) begin
            stable_cnt_q <= stable_cnt_q + 1'b1;
        end
    end

    // ********************************************************
    // Load decision.
    // ********************************************************

    esl_req_t req_d;
    logic refuse_d;
    logic same_code;
    logic go;

    assign same_code = (pins.code == last_code_q);
    // A trigger counts whenever not busy; the timer only for a new code.
    assign go = !busy_q && (measure_start_input_rise || (stable_fire && !same_code));

    // Work out what the trigger or timer asks for.
    always_comb begin
        req_d = '0;
        refuse_d = 1'b0;
        if (go) begin
            req_d.code = pins.code;
            req_d.is_channel = pins.multiplexer_mode_input;
            req_d.first_channel = measure_start_input_rise && restart_pend_q;
            if (measure_start_input_rise && same_code && ctrl_q[CTRL_EXT_BIT]) begin
                req_d.valid = 1'b1;
                req_d.measure_only = 1'b1;
            end else if (pins.multiplexer_mode_input && scan_on(scan_mode)) begin
                req_d.valid = measure_start_input_rise;
                req_d.measure_only = 1'b1;
            end else if (pins.multiplexer_mode_input && pins.leads) begin
                refuse_d = 1'b1;
            end else begin
                req_d.valid = 1'b1;
                req_d.switch_ch = pins.multiplexer_mode_input;
            end
        end
    end

    // Issue requests, one cycle pulse.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            load_req_out <= '0;
        end else begin
            load_req_out <= req_d;
        end
    end

    // Remember the loaded code and hold off until firmware acks.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            last_code_q <= CODE_NONE;
            busy_q <= 1'b0;
        end else if (req_d.valid && !req_d.measure_only) begin
            last_code_q <= req_d.code;
            busy_q <= 1'b1;
        end else if (ack_wr) begin
            busy_q <= 1'b0;
        end
    end

    // Fault stays until the code is switched again or any request, measure only included, is issued.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            fault_out <= 1'b0;
        end else if (refuse_d) begin
            fault_out <= 1'b1;
        end else if (pins.code != pins_q.code || req_d.valid) begin
            fault_out <= 1'b0;
        end
    end

    // ********************************************************
    // Scan restart.
    // ********************************************************

    // Step mode takes it while idle; auto mode reserves it too.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            restart_pend_q <= 1'b0;
        end else if (!scan_on(scan_mode)) begin
            restart_pend_q <= 1'b0;
        end else if (restart_rise && (scan_mode == SCAN_AUTO || !busy_q)) begin
            restart_pend_q <= 1'b1;
        end else if (go && measure_start_input_rise) begin
            restart_pend_q <= 1'b0;
        end
    end

    // ********************************************************
    // Key lockout and digit output.
    // ********************************************************

    // Keys are locked whenever a non-zero code is presented.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            key_lock_out <= 1'b0;
        end else begin
            key_lock_out <= (pins.code != CODE_NONE);
        end
    end

    // Half select picks upper or lower digits in decimal mode.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            digits_out <= '0;
        end else if (!ctrl_q[CTRL_DEC_BIT]) begin
            digits_out <= '0;
        end else begin
            digits_out <= pins.half ? lower_q : upper_q;
        end
    end

    // ********************************************************
    // Interrupts.
    // ********************************************************

    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;

    assign ev_set = {restart_rise && scan_on(scan_mode), refuse_d,
        req_d.valid && req_d.measure_only,
        req_d.valid && !req_d.measure_only};
    assign ev_clr = (wr_acc && avs_address == OFF_IRQ_STAT) ?
        avs_writedata[EV_W-1:0] : '0;

    // Sticky status, a new event wins over a clear.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= w1c(irq_stat_q, ev_clr, ev_set);
        end
    end

    // Level interrupt from unmasked status.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(w1c(irq_stat_q, ev_clr, ev_set) & irq_mask_q);
        end
    end

    // ********************************************************
    // Avalon-MM slave.
    // ********************************************************

    // Waitrequest drops for one cycle after a request is seen.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
        end
    end

    // Writable registers.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            ctrl_q <= CTRL_RST;
            irq_mask_q <= '0;
            upper_q <= '0;
            lower_q <= '0;
        end else if (wr_acc) begin
            unique case (avs_address)
                OFF_CTRL: ctrl_q <= avs_writedata[3:0];
                OFF_IRQ_MASK: irq_mask_q <= avs_writedata[EV_W-1:0];
                OFF_UPPER: upper_q <= avs_writedata[15:0];
                OFF_LOWER: lower_q <= avs_writedata[15:0];
                default: ;
            endcase
        end
    end

    // Read data is loaded as waitrequest falls.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            avs_readdata <= '0;
        end else if (avs_read && avs_waitrequest) begin
            unique case (avs_address)
                OFF_CTRL: avs_readdata <= {28'h0000000, ctrl_q};
                OFF_STATUS: avs_readdata <= {18'h00000, fault_out,
                    restart_pend_q, busy_q, key_lock_out, pins.half,
                    pins.multiplexer_mode_input, pins.code, pins.spare};
                OFF_IRQ_STAT: avs_readdata <= {28'h0000000, irq_stat_q};
                OFF_IRQ_MASK: avs_readdata <= {28'h0000000, irq_mask_q};
                OFF_LAST: avs_readdata <= {26'h0000000, last_code_q};
                OFF_UPPER: avs_readdata <= {16'h0000, upper_q};
                OFF_LOWER: avs_readdata <= {16'h0000, lower_q};
                default: avs_readdata <= '0;
            endcase
        end
    end

endmodule : esl_top
`default_nettype wire

// >>> esl_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Port checks of the setting load control.
// ************************************************************
module esl_top_asserts (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Watched pins and bus.
    input wire logic [5:0] setting_select_in,
    input wire logic multiplexer_mode_in,
    input wire logic front_leads_in,
    input wire logic avs_waitrequest,
    // Watched results.
    input wire esl_pkg::esl_req_t load_req_out,
    input wire logic fault_out,
    input wire logic key_lock_out
);
    import esl_pkg::*;
    // All checks sample on the clock and pause in reset.
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_pulse;
        load_req_out.valid |=> !load_req_out.valid;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("request held longer than one cycle");
    property p_code;
        load_req_out.valid && !load_req_out.measure_only &&
        $past(setting_select_in, 2) == $past(setting_select_in, 5)
        |-> load_req_out.code == $past(setting_select_in, 3);
    endproperty
    a_code: assert property (p_code)
        else $error("request code differs from select pins");
    property p_chan;
        load_req_out.valid && !load_req_out.measure_only &&
        $past(multiplexer_mode_in, 2) == $past(multiplexer_mode_in, 5)
        |-> load_req_out.is_channel == $past(multiplexer_mode_in, 3);
    endproperty
    a_chan: assert property (p_chan)
        else $error("panel or channel reading wrong");
    property p_lock;
        $past(setting_select_in, 2) == $past(setting_select_in, 5)
        |-> key_lock_out == ($past(setting_select_in, 3) != CODE_NONE);
    endproperty
    a_lock: assert property (p_lock)
        else $error("key lock does not follow the code");
    property p_fault;
        $rose(fault_out) |-> !load_req_out.valid &&
        $past(front_leads_in, 3) && $past(multiplexer_mode_in, 3);
    endproperty
    a_fault: assert property (p_fault)
        else $error("fault without refused channel switch");
    property p_monly;
        load_req_out.valid && load_req_out.measure_only
        |-> !load_req_out.switch_ch;
    endproperty
    a_monly: assert property (p_monly)
        else $error("measure only request switches");
    property p_first;
        load_req_out.first_channel |-> load_req_out.valid;
    endproperty
    a_first: assert property (p_first)
        else $error("first channel flag without request");
    property p_quiet;
        $rose(rst_n_in) |-> !load_req_out.valid [*3];
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("request right after reset");
    property p_wait;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait)
        else $error("waitrequest low for more than one cycle");

    // Main scenarios seen at the ports.
    c_first: cover property (load_req_out.valid && load_req_out.first_channel);
    c_fault: cover property ($rose(fault_out));
    c_monly: cover property (load_req_out.valid && load_req_out.measure_only);
endmodule : esl_top_asserts

bind esl_top esl_top_asserts i_esl_top_asserts (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .setting_select_in(setting_select_in),
    .multiplexer_mode_in(multiplexer_mode_in),
    .front_leads_in(front_leads_in),
    .avs_waitrequest(avs_waitrequest),
    .load_req_out(load_req_out),
    .fault_out(fault_out),
    .key_lock_out(key_lock_out)
);
`default_nettype wire

// >>> esl_plc_model.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// External controller driving the control port pins.
// ************************************************************
module esl_plc_model #(
    parameter int HOLD = 100000
) (
    // Clock.
    input wire logic ref_clk_in,
    // Pins.
    output logic measure_start_input_out = 1'b0,
    output logic restart_out = 1'b0,
    output logic [5:0] code_out = 6'h00,
    output logic mux_out = 1'b0,
    output logic half_out = 1'b0,
    output logic leads_out = 1'b0,
    output logic [1:0] spare_out = 2'h0
);
    // Sets the levels and then holds them until the next call.
    task set_pins(input logic [5:0] c, input logic m, input logic l,
                  input logic h, input logic [1:0] s);
        @(posedge ref_clk_in);
        code_out <= c;
        mux_out <= m;
        leads_out <= l;
        half_out <= h;
        spare_out <= s;
        repeat (4) @(posedge ref_clk_in);
    endtask : set_pins

    // Drives the trigger level.
    task measure_start_input(input logic b);
        @(posedge ref_clk_in);
        measure_start_input_out <= b;
    endtask : measure_start_input

    // Holds the restart pin on for the minimum time.
    task restart;
        @(posedge ref_clk_in);
        restart_out <= 1'b1;
        repeat (HOLD) @(posedge ref_clk_in);
        restart_out <= 1'b0;
    endtask : restart
endmodule : esl_plc_model
`default_nettype wire

// >>> test_ext_io_setting_load_control.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Testbench of the setting load control.
// ************************************************************
module test_ext_io_setting_load_control;
    import esl_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic measure_start_input, rstr, multiplexer_mode_input, half, leads, fault, lock, irq, wq;
    logic [5:0] code;
    logic [1:0] spare;
    logic [4:0] avs_address;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata;
    logic [31:0] rdata, junk;
    logic [15:0] digits;
    esl_req_t req_w, r;
    int bad_count = 0;
    int total_checks = 0;

    // Free running 20 MHz clock.
    always #25 ref_clk_in = ~ref_clk_in;

    esl_plc_model #(.HOLD(8)) i_esl_plc_model (.ref_clk_in(ref_clk_in),
        .measure_start_input_out(measure_start_input), .restart_out(rstr), .code_out(code),
        .mux_out(multiplexer_mode_input), .half_out(half), .leads_out(leads),
        .spare_out(spare));
    esl_top #(.STABLE_CYCLES(20)) i_esl_top (.ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in), .measure_start_in(measure_start_input),
        .scan_restart_in(rstr), .setting_select_in(code),
        .multiplexer_mode_in(multiplexer_mode_input), .digit_half_select_in(half),
        .front_leads_in(leads), .spare_in(spare),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(rdata), .avs_waitrequest(wq),
        .load_req_out(req_w), .fault_out(fault), .key_lock_out(lock),
        .digits_out(digits), .irq_out(irq));

    // Compares one value and counts it.
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // One bus transfer, held until waitrequest is seen low.
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
             output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (wq !== 1'b0 && n < 100);
        rd = rdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 100) chk(32'h0, 32'h1, "bus hang");
    endtask : bus

    task wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, junk);
    endtask : wr

    // Reads a register and compares the masked value.
    task rdc(input logic [4:0] a, input logic [31:0] msk,
             input logic [31:0] exp, input string m);
        bus(1'b0, a, 32'h0, junk);
        chk(junk & msk, exp, m);
    endtask : rdc

    // Waits a bounded time for a request pulse.
    task wait_req(output esl_req_t q);
        q = '0;
        for (int n = 0; n < 60; n++) begin
            @(posedge ref_clk_in);
            if (req_w.valid === 1'b1) begin
                q = req_w;
                break;
            end
        end
        if (q.valid !== 1'b1) chk(32'h0, 32'h1, "no request");
    endtask : wait_req

    // Fails on any request during the given span.
    task quiet(input int n);
        repeat (n) begin
            @(posedge ref_clk_in);
            if (req_w.valid === 1'b1) chk(32'h1, 32'h0, "stray request");
        end
    endtask : quiet

    // Trigger edge, captured request, then trigger released.
    task fire(output esl_req_t q);
        i_esl_plc_model.measure_start_input(1'b1);
        wait_req(q);
        i_esl_plc_model.measure_start_input(1'b0);
        repeat (4) @(posedge ref_clk_in);
    endtask : fire

    task print_verdict;
        $display("mismatches %0d checks %0d", bad_count, total_checks);
        if (bad_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    // Main sequence.
    initial begin
        avs_address <= 5'h00;
        avs_writedata <= 32'h0;
        repeat (20) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        i_esl_plc_model.set_pins(6'h00, 1'b0, 1'b0, 1'b0, 2'h2);
        rdc(OFF_CTRL, 32'hffffffff, {28'h0, CTRL_RST}, "ctrl reset");
        rdc(5'h01, 32'hffffffff, 32'h0, "unmapped read");
        rdc(OFF_STATUS, 32'h3, 32'h2, "spare inputs");
        wr(OFF_UPPER, 32'h1234);
        wr(OFF_LOWER, 32'h5678);
        chk(digits, 32'h0, "digits off");
        wr(OFF_CTRL, 32'hc);
        repeat (2) @(posedge ref_clk_in);
        chk(digits, 32'h1234, "upper digits");
        i_esl_plc_model.set_pins(6'h00, 1'b0, 1'b0, 1'b1, 2'h2);
        chk(digits, 32'h5678, "lower digits");
        wr(OFF_CTRL, 32'h8);
        i_esl_plc_model.set_pins(6'h05, 1'b0, 1'b0, 1'b0, 2'h1);
        fire(r);
        chk(r.code, 32'h5, "load code");
        chk(r.measure_only, 32'h0, "full load");
        chk(r.is_channel, 32'h0, "panel load");
        chk(lock, 32'h1, "key lock");
        rdc(OFF_STATUS, 32'hff, 32'h15, "status code");
        wr(OFF_ACK, 32'h1);
        rdc(OFF_LAST, 32'h3f, 32'h5, "last code");
        fire(r);
        chk(r.measure_only, 32'h1, "same code");
        chk(r.switch_ch, 32'h0, "same code switch");
        i_esl_plc_model.set_pins(6'h09, 1'b0, 1'b0, 1'b0, 2'h1);
        wait_req(r);
        chk(r.code, 32'h9, "timer load");
        wr(OFF_ACK, 32'h1);
        quiet(40);
        wr(OFF_IRQ_MASK, 32'h4);
        i_esl_plc_model.set_pins(6'h03, 1'b1, 1'b1, 1'b0, 2'h1);
        i_esl_plc_model.measure_start_input(1'b1);
        quiet(30);
        i_esl_plc_model.measure_start_input(1'b0);
        chk(fault, 32'h1, "fault level");
        rdc(OFF_IRQ_STAT, 32'h4, 32'h4, "refuse event");
        chk(irq, 32'h1, "irq raised");
        wr(OFF_IRQ_STAT, 32'h4);
        repeat (2) @(posedge ref_clk_in);
        chk(irq, 32'h0, "irq cleared");
        i_esl_plc_model.set_pins(6'h07, 1'b1, 1'b0, 1'b0, 2'h1);
        chk(fault, 32'h0, "fault cleared");
        fire(r);
        chk(r.is_channel, 32'h1, "channel load");
        chk(r.switch_ch, 32'h1, "channel switch");
        wr(OFF_ACK, 32'h1);
        wr(OFF_CTRL, 32'h2);
        i_esl_plc_model.restart();
        fire(r);
        chk(r.first_channel, 32'h1, "restart in step");
        chk(r.measure_only, 32'h1, "no switch in scan");
        wr(OFF_CTRL, 32'h1);
        i_esl_plc_model.restart();
        fire(r);
        chk(r.first_channel, 32'h1, "restart in auto");
        chk(r.measure_only, 32'h1, "no switch in auto");
        wr(OFF_CTRL, 32'h8);
        i_esl_plc_model.restart();
        fire(r);
        chk(r.first_channel, 32'h0, "restart scan off");
        print_verdict();
    end

    // Watchdog against a hang.
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        bad_count++;
        print_verdict();
    end
endmodule : test_ext_io_setting_load_control
`default_nettype wire
